/* pkg/prc_cfg.svh */
// constants of the pll reference, phase detector and unlock block
`ifndef PRC_CFG_SVH
`define PRC_CFG_SVH

`define PRC_ADDR_W       7
`define PRC_ADDR_UNLOCK  7'h05
`define PRC_ADDR_MODE    7'h21
`define PRC_ADDR_REF     7'h31

`define PRC_REF_RST      4'hF
`define PRC_MODE_RST     4'h0
`define PRC_UNLOCK_BIT   0

`define PRC_CODE_1K25    4'h0
`define PRC_CODE_2K5     4'h1
`define PRC_CODE_5K      4'h2
`define PRC_CODE_10K     4'h3
`define PRC_CODE_6K25    4'h4
`define PRC_CODE_12K5    4'h5
`define PRC_CODE_25K     4'h6
`define PRC_CODE_50K     4'h7
`define PRC_CODE_3K      4'h8
`define PRC_CODE_1K      4'hC
`define PRC_CODE_9K      4'hD
`define PRC_CODE_100K    4'hE
`define PRC_CODE_OFF     4'hF

`define PRC_MODE_NONE    4'h0
`define PRC_MODE_MF      4'h1
`define PRC_MODE_VHF     4'h2
`define PRC_MODE_HF      4'h3

// crystal rate as a fraction of the system clock
`define PRC_CLK_KHZ      50000
`define PRC_XTAL_KHZ     4500
`define PRC_XTAL_NUM     7'h09
`define PRC_XTAL_DEN     7'h64

// reference divisors in crystal periods
`define PRC_DIV_W        13
`define PRC_DIV_1K25     13'h0E10
`define PRC_DIV_2K5      13'h0708
`define PRC_DIV_5K       13'h0384
`define PRC_DIV_10K      13'h01C2
`define PRC_DIV_6K25     13'h02D0
`define PRC_DIV_12K5     13'h0168
`define PRC_DIV_25K      13'h00B4
`define PRC_DIV_50K      13'h005A
`define PRC_DIV_3K       13'h05DC
`define PRC_DIV_1K       13'h1194
`define PRC_DIV_9K       13'h01F4
`define PRC_DIV_100K     13'h002D

`define PRC_CLK_NS       20
`define PRC_DLY_MIN_NS   800
`define PRC_DLY_MAX_NS   1000
`define PRC_DLY_CYC      ((`PRC_DLY_MIN_NS + `PRC_CLK_NS - 1) / `PRC_CLK_NS)

`endif

/* pkg/prc_pkg.sv */
// types of the pll reference, phase detector and unlock block
package prc_pkg;

  typedef logic [3:0] prc_nib_type;

  typedef enum logic [1:0] {
    PRC_IDLE,
    PRC_UP,
    PRC_DOWN
  } prc_pfd_type;

endpackage : prc_pkg

/* verif/pll_ref_phase_unlock_ctrl_tb.sv */
// self-checking bench for the pll reference, phase detector and unlock block
`include "prc_cfg.svh"
module pll_ref_phase_unlock_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import prc_pkg::*;
  // short 1 kHz divisor keeps the run brief
  localparam logic [`PRC_DIV_W-1:0] DIV_SIM = 13'h0010;
  logic clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, clk_stop_i = 1'b0, ena_i = 1'b1;
  logic wr_s = 1'b0, rd_s = 1'b0, fn, run, rf, up_n, dn_n, eo, oe_n, pdh, pdl;
  logic [`PRC_ADDR_W-1:0] addr = 7'h00;
  prc_nib_type wdat = 4'h0, rdat;
  logic [15:0] half = 16'h0020;
  logic [31:0] seed = 32'h502F53C1;
  int fails = 0, checks_done = 0;
  always #10 clk_i = ~clk_i;
  prc_top #(.DIV_1K(DIV_SIM)) DUT (.clk_i, .nrst_i, .ena_i, .ce_i, .clk_stop_i,
    .rf_addr_i(addr), .rf_wr_i(wr_s), .rf_wdata_i(wdat), .rf_rd_i(rd_s), .rf_rdata_o(rdat),
    .divided_freq_i(fn), .div_run_o(run), .ref_freq_o(rf), .up_request_n_o(up_n),
    .down_request_n_o(dn_n), .error_out_pin_o(eo), .error_out_pin_oe_n_o(oe_n),
    .vco_high_input_pd_o(pdh), .vco_low_input_pd_o(pdl));
  prc_vco_model VCO (.clk_i, .run_i(run), .half_i(half), .fn_o(fn));
  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // crystal averages 9 ticks per 100 clocks, so allow two clocks of jitter
  function automatic logic per_ok(input int n, input int div);
    return n >= div * 100 / 9 - 2 && n <= div * 100 / 9 + 2;
  endfunction : per_ok
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_nib(input prc_nib_type got, input prc_nib_type exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t nibble got %h exp %h", $time, got, exp);
    end
  endtask : chk_nib
  task automatic wr(input logic [`PRC_ADDR_W-1:0] a, input prc_nib_type d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [`PRC_ADDR_W-1:0] a, input prc_nib_type e);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 chk_nib(rdat, e);
  endtask : rdc
  // 0: reference pulse, 1: up request, 2: down request
  task automatic wt(input int s, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (!(s == 0 ? rf : s == 1 ? !up_n : !dn_n) && n < 4000);
    if (n >= 4000) begin
      fails++;
      report_and_stop;
    end
  endtask : wt
  // ==========
  // scenarios
  initial begin
    int n;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdc(`PRC_ADDR_REF, `PRC_REF_RST);
    rdc(`PRC_ADDR_MODE, `PRC_MODE_RST);
    rdc(`PRC_ADDR_UNLOCK, 4'h0);
    rdc(7'h7F, 4'h0);
    chk_bit(oe_n, 1'b1);
    $display("reset test done");
    for (int c = 0; c < 16; c++) begin
      wr(`PRC_ADDR_REF, c[3:0]);
      rdc(`PRC_ADDR_REF, c[3:0]);
      chk_bit(run, c != 15);
    end
    wr(`PRC_ADDR_REF, `PRC_CODE_1K);
    for (int m = 0; m < 4; m++) begin
      wr(`PRC_ADDR_MODE, m[3:0]);
      #1 chk_bit(pdh, m != 2);
      chk_bit(pdl, m == 0 || m == 2);
      chk_bit(run, 1'b1);
    end
    $display("code and mode test done");
    wr(`PRC_ADDR_REF, `PRC_CODE_100K);
    wt(0, n);
    wt(0, n);
    chk_bit(per_ok(n, `PRC_DIV_100K), 1'b1);
    wr(`PRC_ADDR_REF, `PRC_CODE_1K);
    wt(0, n);
    wt(0, n);
    chk_bit(per_ok(n, DIV_SIM), 1'b1);
    $display("reference period test done");
    seed = lfsr(seed);
    half <= 16'h00C8 + 16'(seed[5:0]);
    wt(1, n);
    chk_bit(eo, 1'b0);
    chk_bit(oe_n, 1'b0);
    repeat (400) @(posedge clk_i);
    rdc(`PRC_ADDR_UNLOCK, 4'h1); // polled slower than a period
    repeat (400) @(posedge clk_i);
    wr(`PRC_ADDR_REF, `PRC_CODE_OFF);
    wr(`PRC_ADDR_UNLOCK, 4'h0);
    rdc(`PRC_ADDR_UNLOCK, 4'h1);
    rdc(`PRC_ADDR_UNLOCK, 4'h0);
    $display("up and unlock test done");
    seed = lfsr(seed);
    half <= 16'h0014 + 16'(seed[3:0]);
    wr(`PRC_ADDR_REF, `PRC_CODE_1K);
    wt(2, n);
    chk_bit(eo, 1'b1);
    chk_bit(oe_n, 1'b0);
    @(posedge clk_i);
    ce_i <= 1'b0;
    @(posedge clk_i);
    #1 chk_bit(up_n & dn_n & oe_n & pdh & pdl & ~run, 1'b1);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rdc(`PRC_ADDR_REF, `PRC_CODE_1K);
    rdc(`PRC_ADDR_MODE, 4'h3);
    wr(`PRC_ADDR_REF, `PRC_CODE_OFF); // software disables after chip enable
    $display("down and chip enable test done");
    wr(`PRC_ADDR_REF, `PRC_CODE_1K);
    @(posedge clk_i);
    clk_stop_i <= 1'b1;
    @(posedge clk_i);
    clk_stop_i <= 1'b0;
    rdc(`PRC_ADDR_REF, `PRC_CODE_OFF);
    rdc(`PRC_ADDR_MODE, `PRC_MODE_RST);
    chk_bit(oe_n & pdh & pdl & ~run, 1'b1);
    ena_i <= 1'b0;
    wr(`PRC_ADDR_REF, `PRC_CODE_1K);
    ena_i <= 1'b1;
    rdc(`PRC_ADDR_REF, `PRC_CODE_OFF); // frozen write is lost
    $display("clock stop test done");
    report_and_stop;
  end
endmodule : pll_ref_phase_unlock_ctrl_tb

/* verif/prc_top_properties.sv */
// port assertions for the pll reference, phase detector and unlock block
`include "prc_cfg.svh"
module prc_top_properties #(
  parameter logic [`PRC_DIV_W-1:0] DIV_1K = `PRC_DIV_1K
) (
  input wire logic                   clk_i,
  input wire logic                   nrst_i,
  input wire logic                   ena_i,
  input wire logic                   ce_i,
  input wire logic [`PRC_ADDR_W-1:0] rf_addr_i,
  input wire logic                   rf_rd_i,
  input wire prc_pkg::prc_nib_type   rf_rdata_o,
  input wire logic                   divided_freq_i,
  input wire logic                   div_run_o,
  input wire logic                   ref_freq_o,
  input wire logic                   up_request_n_o,
  input wire logic                   down_request_n_o,
  input wire logic                   error_out_pin_o,
  input wire logic                   error_out_pin_oe_n_o,
  input wire logic                   vco_high_input_pd_o,
  input wire logic                   vco_low_input_pd_o
);
  import prc_pkg::*;
  logic fn_d;
  logic fn_rose;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge clk_i) fn_d <= divided_freq_i;
  assign fn_rose = divided_freq_i & ~fn_d;
  // ==========
  // properties
  sequence s_rd05;
    ena_i && rf_rd_i && rf_addr_i == `PRC_ADDR_UNLOCK;
  endsequence
  property p_ce_off;
    !ce_i |-> !div_run_o && error_out_pin_oe_n_o && vco_high_input_pd_o && vco_low_input_pd_o;
  endproperty
  property p_code_off;
    !div_run_o |-> error_out_pin_oe_n_o && vco_high_input_pd_o && vco_low_input_pd_o;
  endproperty
  property p_quiet;
    !div_run_o |-> up_request_n_o && down_request_n_o;
  endproperty
  property p_drive;
    !up_request_n_o || !down_request_n_o
      |-> !error_out_pin_oe_n_o && error_out_pin_o == up_request_n_o;
  endproperty
  property p_float;
    up_request_n_o && down_request_n_o |-> error_out_pin_oe_n_o;
  endproperty
  property p_ref_pulse;
    ref_freq_o |-> $past(ce_i) ##1 !ref_freq_o;
  endproperty
  property p_rd_bits;
    s_rd05 |=> rf_rdata_o[3:1] == 3'h0;
  endproperty
  // no reference tick may set the flag between the two reads
  property p_rd_clr;
    s_rd05 ##1 !ref_freq_o ##1 (s_rd05 and !ref_freq_o) ##1 !ref_freq_o |-> rf_rdata_o == 4'h0;
  endproperty
  property p_up_dly;
    $fell(up_request_n_o) |-> $past(ref_freq_o, 40);
  endproperty
  property p_dn_dly;
    $fell(down_request_n_o) |-> $past(fn_rose, 41);
  endproperty
  a_ce_off: assert property (p_ce_off)
    else $error("chip enable low left pll active");
  a_code_off: assert property (p_code_off)
    else $error("disabled pll drives pins");
  a_quiet: assert property (p_quiet)
    else $error("request while disabled");
  a_drive: assert property (p_drive)
    else $error("error out level wrong");
  a_float: assert property (p_float)
    else $error("error out driven with no request");
  a_ref_pulse: assert property (p_ref_pulse)
    else $error("reference pulse malformed");
  a_rd_bits: assert property (p_rd_bits)
    else $error("unlock status upper bits set");
  a_rd_clr: assert property (p_rd_clr)
    else $error("unlock flag not cleared by read");
  a_up_dly: assert property (p_up_dly)
    else $error("up request delay wrong");
  a_dn_dly: assert property (p_dn_dly)
    else $error("down request delay wrong");
endmodule : prc_top_properties

bind prc_top prc_top_properties #(.DIV_1K(DIV_1K)) u_prc_props (.clk_i, .nrst_i, .ena_i,
  .ce_i, .rf_addr_i, .rf_rd_i, .rf_rdata_o, .divided_freq_i, .div_run_o, .ref_freq_o,
  .up_request_n_o, .down_request_n_o, .error_out_pin_o, .error_out_pin_oe_n_o,
  .vco_high_input_pd_o, .vco_low_input_pd_o);

/* verif/prc_vco_model.sv */
// divided vco model: square wave on the divider output while dividing is allowed
module prc_vco_model (
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic [15:0] half_i,
  output logic             fn_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_reg;
  initial fn_o = 1'b0;
  initial cnt_reg = 16'h0000;
  always @(posedge clk_i) begin
    if (!run_i) begin // divider held while stopped
      cnt_reg <= 16'h0000;
      fn_o <= 1'b0;
    end else if (cnt_reg + 16'h0001 >= half_i) begin
      cnt_reg <= 16'h0000;
      fn_o <= ~fn_o;
    end else cnt_reg <= cnt_reg + 16'h0001;
  end
endmodule : prc_vco_model

/* verilog/prc_top.sv */
// pll reference generator, phase detector, charge pump drive and unlock flag
//
// How it works
// - reference is divided down from 4.5 MHz crystal
// - four-bit code picks one of twelve references
// - code all ones disables divider, reference, comparator
// - disabled by code: vco pins pulled, error floats
// - up when divided slower, down when faster
// - no requests while synthesizer disabled
// - error low, high, or floating when equal
// - unlock flag set when a request is active at the reference tick
// - unlock flag set once per reference period
// - reading unlock status returns and clears it
// - unlock status is read only
// - request delay fixed between 0.8 and 1.0 us
// - chip enable low disables whole synthesizer
// - chip enable low keeps select registers
// - power-on reset loads reference code all ones
// - vco mode zero only pulls vco pins down
// - clock stop instruction loads reference code ones
// - unlock status sits at register address 05h
`include "prc_cfg.svh"

module prc_top #(
  parameter logic [`PRC_DIV_W-1:0] DIV_1K = `PRC_DIV_1K
) (
  // clock, reset and control
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   ena_i,
  input  wire logic                   ce_i,
  input  wire logic                   clk_stop_i,
  // register file access
  input  wire logic [`PRC_ADDR_W-1:0] rf_addr_i,
  input  wire logic                   rf_wr_i,
  input  wire prc_pkg::prc_nib_type   rf_wdata_i,
  input  wire logic                   rf_rd_i,
  output prc_pkg::prc_nib_type        rf_rdata_o,
  // divider, comparator and charge pump
  input  wire logic                   divided_freq_i,
  output logic                        div_run_o,
  output logic                        ref_freq_o,
  output logic                        up_request_n_o,
  output logic                        down_request_n_o,
  output logic                        error_out_pin_o,
  output logic                        error_out_pin_oe_n_o,
  // vco input pull-downs
  output logic                        vco_high_input_pd_o,
  output logic                        vco_low_input_pd_o
);
  import prc_pkg::*;

  localparam int DLY = `PRC_DLY_CYC;

  // ==========================================================
  // functions
  // ==========================================================
  function automatic logic [`PRC_DIV_W-1:0] ref_div(input prc_nib_type code,
                                                   input logic [`PRC_DIV_W-1:0] d1k);
    case (code)
      `PRC_CODE_1K25: ref_div = `PRC_DIV_1K25;
      `PRC_CODE_2K5:  ref_div = `PRC_DIV_2K5;
      `PRC_CODE_5K:   ref_div = `PRC_DIV_5K;
      `PRC_CODE_10K:  ref_div = `PRC_DIV_10K;
      `PRC_CODE_6K25: ref_div = `PRC_DIV_6K25;
      `PRC_CODE_12K5: ref_div = `PRC_DIV_12K5;
      `PRC_CODE_25K:  ref_div = `PRC_DIV_25K;
      `PRC_CODE_50K:  ref_div = `PRC_DIV_50K;
      `PRC_CODE_3K:   ref_div = `PRC_DIV_3K;
      `PRC_CODE_1K:   ref_div = d1k;
      `PRC_CODE_9K:   ref_div = `PRC_DIV_9K;
      `PRC_CODE_100K: ref_div = `PRC_DIV_100K;
      // prohibited codes and off: generator stays silent
      default:        ref_div = '0;
    endcase
  endfunction : ref_div

  function automatic logic addr_hit(input logic [`PRC_ADDR_W-1:0] a,
                                    input logic [`PRC_ADDR_W-1:0] b);
    addr_hit = (a == b);
  endfunction : addr_hit

  // ==========================================================
  // registers
  // ==========================================================
  prc_nib_type               ref_code_reg;
  prc_nib_type               ref_code_next;
  prc_nib_type               mode_reg;
  prc_nib_type               mode_next;
  logic                      unlock_reg;
  logic                      unlock_next;
  prc_nib_type               rdata_reg;
  prc_nib_type               rdata_next;

  wire logic wr_ref    = rf_wr_i & addr_hit(rf_addr_i, `PRC_ADDR_REF);
  wire logic wr_mode   = rf_wr_i & addr_hit(rf_addr_i, `PRC_ADDR_MODE);
  wire logic rd_unlock = rf_rd_i & addr_hit(rf_addr_i, `PRC_ADDR_UNLOCK);
  wire logic rd_ref    = rf_rd_i & addr_hit(rf_addr_i, `PRC_ADDR_REF);
  wire logic rd_mode   = rf_rd_i & addr_hit(rf_addr_i, `PRC_ADDR_MODE);

  // clock stop wins over a write in the same cycle
  assign ref_code_next = clk_stop_i ? `PRC_REF_RST :
                         wr_ref     ? rf_wdata_i : ref_code_reg;
  assign mode_next     = clk_stop_i ? `PRC_MODE_RST :
                         wr_mode    ? rf_wdata_i : mode_reg;

  // ==========================================================
  // disable decode
  // ==========================================================
  // prohibited codes keep the loop enabled but give no reference
  wire logic code_off = (ref_code_reg == `PRC_CODE_OFF);
  wire logic pll_off  = code_off | ~ce_i;
  wire logic mode_none = (mode_reg == `PRC_MODE_NONE);
  wire logic pins_off = pll_off | mode_none;
  wire logic vhf_sel  = (mode_reg == `PRC_MODE_VHF);

  // ==========================================================
  // crystal tick and reference divider
  // ==========================================================
  logic [6:0]                acc_reg;
  logic [6:0]                acc_next;
  logic [`PRC_DIV_W-1:0]     rcnt_reg;
  logic [`PRC_DIV_W-1:0]     rcnt_next;
  logic                      ref_tick_reg;

  // 4.5 of 50 MHz as a 9/100 accumulator: jitter of one clock is fine
  wire logic [7:0] acc_sum  = {1'b0, acc_reg} + {1'b0, `PRC_XTAL_NUM};
  wire logic       xtal_tk  = (acc_sum >= {1'b0, `PRC_XTAL_DEN});
  wire logic [6:0] acc_wrap = 7'(acc_sum - {1'b0, `PRC_XTAL_DEN});
  assign acc_next = xtal_tk ? acc_wrap : acc_sum[6:0];

  wire logic [`PRC_DIV_W-1:0] div_val = ref_div(ref_code_reg, DIV_1K);
  wire logic div_ok  = (div_val != '0);
  wire logic rcnt_end = xtal_tk & (rcnt_reg >= div_val - 1'b1);
  wire logic ref_tick = ~pll_off & div_ok & rcnt_end;

  assign rcnt_next = (pll_off | ~div_ok) ? '0 :
                     rcnt_end ? '0 :
                     xtal_tk  ? rcnt_reg + 1'b1 : rcnt_reg;

  // ==========================================================
  // phase detector
  // ==========================================================
  prc_pfd_type               pfd_reg;
  prc_pfd_type               pfd_next;
  logic                      fn_d_reg;

  // divider output only counts while the divider runs
  wire logic fn_edge = divided_freq_i & ~fn_d_reg & ~pll_off;
  // an edge alone opens a request, coincident edges mean in phase
  wire logic up_go   = ref_tick & ~fn_edge;
  wire logic dn_go   = fn_edge & ~ref_tick;

  always_comb begin
    pfd_next = pfd_reg;
    case (pfd_reg)
      PRC_IDLE: begin
        if (up_go) begin
          pfd_next = PRC_UP;
        end else if (dn_go) begin
          pfd_next = PRC_DOWN;
        end
      end
      PRC_UP: begin
        if (fn_edge) begin
          pfd_next = PRC_IDLE;
        end
      end
      PRC_DOWN: begin
        if (ref_tick) begin
          pfd_next = PRC_IDLE;
        end
      end
      default: pfd_next = PRC_IDLE;
    endcase
    if (pll_off) begin
      pfd_next = PRC_IDLE;
    end
  end

  // ==========================================================
  // request delay line
  // ==========================================================
  logic [DLY-1:0]            up_dly_reg;
  logic [DLY-1:0]            up_dly_next;
  logic [DLY-1:0]            dn_dly_reg;
  logic [DLY-1:0]            dn_dly_next;

  wire logic up_raw = (pfd_reg == PRC_UP);
  wire logic dn_raw = (pfd_reg == PRC_DOWN);
  // fixed shift of the minimum delay keeps pulse width intact
  wire logic up_act = up_dly_reg[DLY-1] & ~pll_off;
  wire logic dn_act = dn_dly_reg[DLY-1] & ~pll_off;

  assign up_dly_next = pll_off ? '0 : {up_dly_reg[DLY-2:0], up_raw};
  assign dn_dly_next = pll_off ? '0 : {dn_dly_reg[DLY-2:0], dn_raw};

  // ==========================================================
  // unlock flag and read data
  // ==========================================================
  // sampled on the reference tick only; a set beats a read clear
  wire logic any_act    = up_act | dn_act;
  wire logic unlock_set = ref_tick & any_act;
  assign unlock_next = unlock_set ? 1'b1 :
                       rd_unlock  ? 1'b0 : unlock_reg;

  // writes to the unlock address decode nowhere
  assign rdata_next =
    rd_unlock ? {3'h0, unlock_reg} :
    rd_ref  ? ref_code_reg :
    rd_mode ? mode_reg :
    rf_rd_i ? 4'h0 : rdata_reg;

  // ==========================================================
  // state
  // ==========================================================
  // ce is no reset here: selects survive chip enable low
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ref_code_reg <= `PRC_REF_RST;
      mode_reg     <= `PRC_MODE_RST;
    end else if (ena_i) begin
      ref_code_reg <= ref_code_next;
      mode_reg     <= mode_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_reg      <= 7'h00;
      rcnt_reg     <= '0;
      ref_tick_reg <= 1'b0;
    end else if (ena_i) begin
      acc_reg      <= acc_next;
      rcnt_reg     <= rcnt_next;
      ref_tick_reg <= ref_tick;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fn_d_reg     <= 1'b0;
      pfd_reg      <= PRC_IDLE;
    end else if (ena_i) begin
      fn_d_reg     <= divided_freq_i;
      pfd_reg      <= pfd_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      up_dly_reg <= '0;
      dn_dly_reg <= '0;
    end else if (ena_i) begin
      up_dly_reg <= up_dly_next;
      dn_dly_reg <= dn_dly_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      unlock_reg <= 1'b0;
    end else if (ena_i) begin
      unlock_reg <= unlock_next;
    end
  end

  // read data holds between reads, so a slow poll still sees it
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_reg  <= 4'h0;
    end else if (ena_i) begin
      rdata_reg  <= rdata_next;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign rf_rdata_o       = rdata_reg;
  assign ref_freq_o       = ref_tick_reg;
  assign div_run_o        = ~pll_off;
  assign up_request_n_o   = ~up_act;
  assign down_request_n_o = ~dn_act;

  // up pulls the loop low, down drives high, neither floats
  wire logic eo_low   = up_act & ~dn_act;
  wire logic eo_high  = dn_act & ~up_act;
  wire logic eo_drive = (eo_low | eo_high) & ~pll_off;
  assign error_out_pin_o      = eo_high;
  assign error_out_pin_oe_n_o = ~eo_drive;

  // mf and hf take the low input, vhf the high one
  assign vco_high_input_pd_o = pins_off | ~vhf_sel;
  assign vco_low_input_pd_o  = pins_off | vhf_sel;

endmodule : prc_top
